// File: tcap_pkg.sv
package tcap_pkg;
  // Register byte addresses (one aligned word each)
  localparam int          ADDR_W     = 12;
  localparam logic [11:0] OFF_TSC    = 12'h000;
  localparam logic [11:0] OFF_CNT_HI = 12'h004;
  localparam logic [11:0] OFF_CNT_LO = 12'h008;
  localparam logic [11:0] OFF_MOD_HI = 12'h00c;
  localparam logic [11:0] OFF_MOD_LO = 12'h010;
  localparam logic [11:0] CH_BASE    = 12'h020;
  localparam logic [11:0] CH_STRIDE  = 12'h010;
  localparam logic [11:0] CH_SC_OFF  = 12'h000;
  localparam logic [11:0] CH_VH_OFF  = 12'h004;
  localparam logic [11:0] CH_VL_OFF  = 12'h008;
  // Flag bit position in both status/control bytes
  localparam int          FLAG_BIT   = 7;
  localparam logic [15:0] CNT_ZERO   = 16'h0000;
  localparam logic [15:0] CNT_FULL   = 16'hffff;
  localparam logic [1:0]  RESP_OKAY  = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam int          CH_MAX     = 8;

  typedef enum logic [1:0] {
    CLK_OFF   = 2'b00,
    CLK_BUS   = 2'b01,
    CLK_FIXED = 2'b10,
    CLK_EXT   = 2'b11
  } tcap_clksrc_t;

  typedef enum logic [1:0] {
    MODE_CAPTURE = 2'b00,
    MODE_COMPARE = 2'b01,
    MODE_EPWM_A  = 2'b10,
    MODE_EPWM_B  = 2'b11
  } tcap_chmode_t;

  // Timer status/control byte, bit 7 down to bit 0
  typedef struct packed {
    logic         overflow_flag;
    logic         overflow_irq_enable;
    logic         center_align_select;
    tcap_clksrc_t clock_select;
    logic [2:0]   prescale;
  } tcap_tsc_t;

  // Channel status/control byte, bits 1:0 read zero
  typedef struct packed {
    logic         channel_event_flag;
    logic         channel_irq_enable;
    tcap_chmode_t channel_mode;
    logic [1:0]   edge_level;
    logic [1:0]   unused;
  } tcap_chsc_t;

  localparam tcap_tsc_t  TSC_RESET  = '0;
  localparam tcap_chsc_t CHSC_RESET = '0;
endpackage : tcap_pkg

// File: tcap_top.sv
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Operation
// - One 16-bit counter, modulus, clock, prescale
// - Center select: up/down counter, else up only
// - Clock select 00 off, else three sources
// - Reset clears clock select, counter stopped
// - Select 00 stops counter, values kept
// - External clock synchronised, max quarter rate
// - Shared pin channel: compare, pin disabled
// - Overflow interrupt when flag and enable
// - Free up count wraps 0xFFFF, sets flag
// - Limited up count wraps at modulus
// - Up/down sets flag leaving modulus downward
// - Up/down turns at limit and zero
// - Terminal count is modulus or 0xFFFF
// - Counter write zeroes counter and latch
// - Mode bits pick capture, compare, PWM; the PWM codes do nothing here
// - Active edge copies counter to channel; not under center select here
// - Capture mode value bytes are read only; writable under center select here
// - Byte read latches other byte coherently
// - Channel control write clears read latch
// - Capture sets channel flag, optional interrupt
// - Capture works during debug halt
// - Edge bits 01 rise, 10 fall, 11 both
// - Zero modulus means free running
// - Debug halt freezes read latches
module tcap_top #(
  parameter int NCH = 2
) (
  input  wire logic           core_clk,
  input  wire logic           rst,
  input  wire logic [11:0]    s_axi_awaddr,
  input  wire logic           s_axi_awvalid,
  output logic                s_axi_awready,
  input  wire logic [31:0]    s_axi_wdata,
  input  wire logic [3:0]     s_axi_wstrb,
  input  wire logic           s_axi_wvalid,
  output logic                s_axi_wready,
  output logic [1:0]          s_axi_bresp,
  output logic                s_axi_bvalid,
  input  wire logic           s_axi_bready,
  input  wire logic [11:0]    s_axi_araddr,
  input  wire logic           s_axi_arvalid,
  output logic                s_axi_arready,
  output logic [31:0]         s_axi_rdata,
  output logic [1:0]          s_axi_rresp,
  output logic                s_axi_rvalid,
  input  wire logic           s_axi_rready,
  input  wire logic           fixed_clk,
  input  wire logic           ext_clk_pin,
  input  wire logic [NCH-1:0] ch_pin,
  input  wire logic           debug_halt,
  output logic                overflow_irq,
  output logic [NCH-1:0]      channel_irq,
  output logic [NCH-1:0]      ch_pin_oe
);
  import tcap_pkg::*;

  if (NCH < 1 || NCH > CH_MAX) begin : g_bad_nch
    $error("tcap_top: NCH must be 1 to 8");
  end

  function automatic logic [11:0] ch_addr(input int n, input logic [11:0] off);
    ch_addr = 12'(CH_BASE + CH_STRIDE * 12'(n) + off);
  endfunction : ch_addr

  function automatic logic [6:0] pre_mask(input logic [2:0] ps);
    pre_mask = 7'((8'h01 << ps) - 8'h01);
  endfunction : pre_mask

  tcap_tsc_t   tsc;
  logic [15:0] cnt, modulus, cnt_buf, term;
  logic        count_down, cnt_lat, tof_armed;
  logic [6:0]  pre_cnt;
  logic        ext_s1, ext_s2, ext_s3, fix_q, src_edge, tick, ovf_event, at_term;
  tcap_chsc_t  ch_sc   [NCH];
  logic [15:0] ch_val  [NCH];
  logic [15:0] ch_buf  [NCH];
  logic [NCH-1:0] ch_lat, ch_armed, pin_q, cap_ev, cmp_ev;
  logic [NCH-1:0] ch_sc_wr, ch_vh_wr, ch_vl_wr, ch_sc_rd, ch_vh_rd, ch_vl_rd;
  // Bus slave state
  logic        aw_hold, w_hold, do_write, rd_fire;
  logic [11:0] wa, ra;
  logic [7:0]  wbyte;
  logic        wlane;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        w_mapped, cnt_wr, tsc_wr, tsc_rd, cnt_hi_rd, cnt_lo_rd;

  // Write channels taken in either order, response after both
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign do_write      = aw_hold && w_hold && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_fire       = s_axi_arvalid && s_axi_arready;
  assign ra            = {s_axi_araddr[11:2], 2'b00};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      wa           <= '0;
      wbyte        <= '0;
      wlane        <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        wa      <= {s_axi_awaddr[11:2], 2'b00};
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        wbyte  <= s_axi_wdata[7:0];
        wlane  <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= w_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Address decode; a write without byte lane 0 changes nothing
  always_comb begin
    w_mapped  = (wa == OFF_TSC) || (wa == OFF_CNT_HI) || (wa == OFF_CNT_LO) ||
                (wa == OFF_MOD_HI) || (wa == OFF_MOD_LO);
    tsc_wr    = do_write && wlane && (wa == OFF_TSC);
    cnt_wr    = do_write && wlane && (wa == OFF_CNT_HI || wa == OFF_CNT_LO);
    tsc_rd    = rd_fire && (ra == OFF_TSC);
    cnt_hi_rd = rd_fire && (ra == OFF_CNT_HI);
    cnt_lo_rd = rd_fire && (ra == OFF_CNT_LO);
    for (int i = 0; i < NCH; i++) begin
      ch_sc_wr[i] = do_write && wlane && (wa == ch_addr(i, CH_SC_OFF));
      ch_vh_wr[i] = do_write && wlane && (wa == ch_addr(i, CH_VH_OFF));
      ch_vl_wr[i] = do_write && wlane && (wa == ch_addr(i, CH_VL_OFF));
      ch_sc_rd[i] = rd_fire && (ra == ch_addr(i, CH_SC_OFF));
      ch_vh_rd[i] = rd_fire && (ra == ch_addr(i, CH_VH_OFF));
      ch_vl_rd[i] = rd_fire && (ra == ch_addr(i, CH_VL_OFF));
      if (wa == ch_addr(i, CH_SC_OFF) || wa == ch_addr(i, CH_VH_OFF) ||
          wa == ch_addr(i, CH_VL_OFF)) begin
        w_mapped = 1'b1;
      end
    end
  end

  // Read mux; a latched read outside debug halt shows the buffer, any other read live data
  always_comb begin
    next_rdata = '0;
    next_rresp = RESP_OKAY;
    if (ra == OFF_TSC) begin
      next_rdata[7:0] = tsc;
    end else if (ra == OFF_CNT_HI) begin
      next_rdata[7:0] = (cnt_lat && !debug_halt) ? cnt_buf[15:8] : cnt[15:8];
    end else if (ra == OFF_CNT_LO) begin
      next_rdata[7:0] = (cnt_lat && !debug_halt) ? cnt_buf[7:0] : cnt[7:0];
    end else if (ra == OFF_MOD_HI) begin
      next_rdata[7:0] = modulus[15:8];
    end else if (ra == OFF_MOD_LO) begin
      next_rdata[7:0] = modulus[7:0];
    end else begin
      next_rresp = RESP_SLVERR;
    end
    for (int i = 0; i < NCH; i++) begin
      if (ch_sc_rd[i]) begin
        next_rdata = {24'h000000, ch_sc[i]};
        next_rresp = RESP_OKAY;
      end
      if (ch_vh_rd[i]) begin
        next_rdata = {24'h000000, (ch_lat[i] && !debug_halt) ? ch_buf[i][15:8] : ch_val[i][15:8]};
        next_rresp = RESP_OKAY;
      end
      if (ch_vl_rd[i]) begin
        next_rdata = {24'h000000, (ch_lat[i] && !debug_halt) ? ch_buf[i][7:0] : ch_val[i][7:0]};
        next_rresp = RESP_OKAY;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (rd_fire) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= next_rdata;
      s_axi_rresp  <= next_rresp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Clock sources; the external pin is resynchronised, so it must stay
  // below a quarter of core_clk to show clean edges
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ext_s1 <= 1'b0;
      ext_s2 <= 1'b0;
      ext_s3 <= 1'b0;
      fix_q  <= 1'b0;
    end else begin
      ext_s1 <= ext_clk_pin;
      ext_s2 <= ext_s1;
      ext_s3 <= ext_s2;
      fix_q  <= fixed_clk;
    end
  end

  always_comb begin
    case (tsc.clock_select)
      CLK_BUS:   src_edge = 1'b1;
      CLK_FIXED: src_edge = fixed_clk && !fix_q;
      CLK_EXT:   src_edge = ext_s2 && !ext_s3;
      default:   src_edge = 1'b0;
    endcase
  end

  // Prescaler; debug halt freezes the count
  assign tick = src_edge && !debug_halt &&
                ((pre_cnt & pre_mask(tsc.prescale)) == pre_mask(tsc.prescale));

  always_ff @(posedge core_clk) begin
    if (rst || cnt_wr) begin
      pre_cnt <= '0;
    end else if (src_edge && !debug_halt) begin
      pre_cnt <= pre_cnt + 7'h01;
    end
  end

  assign term      = (modulus == CNT_ZERO) ? CNT_FULL : modulus;
  assign at_term   = (cnt == term);
  assign ovf_event = tick && !cnt_wr && at_term && (!tsc.center_align_select || !count_down);

  // Main counter: up mode wraps at term, up/down turns at term and zero
  always_ff @(posedge core_clk) begin
    if (rst || cnt_wr) begin
      cnt        <= CNT_ZERO;
      count_down <= 1'b0;
    end else if (tick) begin
      if (!tsc.center_align_select) begin
        cnt        <= at_term ? CNT_ZERO : cnt + 16'h0001;
        count_down <= 1'b0;
      end else if (!count_down) begin
        count_down <= at_term;
        cnt        <= at_term ? cnt - 16'h0001 : cnt + 16'h0001;
      end else begin
        count_down <= (cnt != CNT_ZERO);
        cnt        <= (cnt == CNT_ZERO) ? cnt + 16'h0001 : cnt - 16'h0001;
      end
    end
  end

  // Counter read coherency; frozen under debug halt
  always_ff @(posedge core_clk) begin
    if (rst || cnt_wr) begin
      cnt_lat <= 1'b0;
      cnt_buf <= CNT_ZERO;
    end else if ((cnt_hi_rd || cnt_lo_rd) && !debug_halt) begin
      cnt_lat <= !cnt_lat;
      if (!cnt_lat) begin
        cnt_buf <= cnt;
      end
    end
  end

  // Modulus bytes
  always_ff @(posedge core_clk) begin
    if (rst) begin
      modulus <= CNT_ZERO;
    end else if (do_write && wlane && wa == OFF_MOD_HI) begin
      modulus[15:8] <= wbyte;
    end else if (do_write && wlane && wa == OFF_MOD_LO) begin
      modulus[7:0] <= wbyte;
    end
  end

  // Timer control; overflow flag set wins over the software clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tsc       <= TSC_RESET;
      tof_armed <= 1'b0;
    end else begin
      if (tsc_wr) begin
        tsc.overflow_irq_enable <= wbyte[6];
        tsc.center_align_select <= wbyte[5];
        tsc.clock_select        <= tcap_clksrc_t'(wbyte[4:3]);
        tsc.prescale            <= wbyte[2:0];
      end
      if (ovf_event) begin
        tsc.overflow_flag <= 1'b1;
      end else if (tsc_wr && !wbyte[FLAG_BIT] && tof_armed) begin
        tsc.overflow_flag <= 1'b0;
      end
      if (tsc_wr) begin
        tof_armed <= 1'b0;
      end else if (tsc_rd && tsc.overflow_flag) begin
        tof_armed <= 1'b1;
      end
    end
  end

  // Channel events with center select clear: capture on selected edge, software compare on match
  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      cap_ev[i] = !tsc.center_align_select && ch_sc[i].channel_mode == MODE_CAPTURE &&
                  ((ch_sc[i].edge_level[0] && ch_pin[i] && !pin_q[i]) ||
                   (ch_sc[i].edge_level[1] && !ch_pin[i] && pin_q[i]));
      cmp_ev[i] = !tsc.center_align_select && ch_sc[i].channel_mode == MODE_COMPARE &&
                  tick && (cnt == ch_val[i]);
    end
  end

  // Channel registers
  always_ff @(posedge core_clk) begin
    if (rst) begin
      pin_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        ch_sc[i]  <= CHSC_RESET;
        ch_val[i] <= CNT_ZERO;
      end
      ch_armed <= '0;
    end else begin
      pin_q <= ch_pin;
      for (int i = 0; i < NCH; i++) begin
        if (ch_sc_wr[i]) begin
          ch_sc[i].channel_irq_enable <= wbyte[6];
          ch_sc[i].channel_mode       <= tcap_chmode_t'(wbyte[5:4]);
          ch_sc[i].edge_level         <= wbyte[3:2];
        end
        if (cap_ev[i] || cmp_ev[i]) begin
          ch_sc[i].channel_event_flag <= 1'b1;
        end else if (ch_sc_wr[i] && !wbyte[FLAG_BIT] && ch_armed[i]) begin
          ch_sc[i].channel_event_flag <= 1'b0;
        end
        if (ch_sc_wr[i]) begin
          ch_armed[i] <= 1'b0;
        end else if (ch_sc_rd[i] && ch_sc[i].channel_event_flag) begin
          ch_armed[i] <= 1'b1;
        end
        if (cap_ev[i]) begin
          ch_val[i] <= cnt;
        end else if (ch_sc[i].channel_mode != MODE_CAPTURE ||
                     tsc.center_align_select) begin
          if (ch_vh_wr[i]) begin
            ch_val[i][15:8] <= wbyte;
          end else if (ch_vl_wr[i]) begin
            ch_val[i][7:0] <= wbyte;
          end
        end
      end
    end
  end

  // Channel read coherency; control write clears even under debug halt
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch_lat <= '0;
      for (int i = 0; i < NCH; i++) begin
        ch_buf[i] <= CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < NCH; i++) begin
        if (ch_sc_wr[i]) begin
          ch_lat[i] <= 1'b0;
        end else if ((ch_vh_rd[i] || ch_vl_rd[i]) && !debug_halt) begin
          ch_lat[i] <= !ch_lat[i];
          if (!ch_lat[i]) begin
            ch_buf[i] <= ch_val[i];
          end
        end
      end
    end
  end

  // Interrupt lines and pin drive; no output waveform is generated
  always_ff @(posedge core_clk) begin
    if (rst) begin
      overflow_irq <= 1'b0;
      channel_irq  <= '0;
      ch_pin_oe    <= '0;
    end else begin
      overflow_irq <= tsc.overflow_flag && tsc.overflow_irq_enable;
      for (int i = 0; i < NCH; i++) begin
        channel_irq[i] <= ch_sc[i].channel_event_flag && ch_sc[i].channel_irq_enable;
      end
      ch_pin_oe <= '0;
    end
  end

  property p_reset_stop;
    @(posedge core_clk) $past(rst) |-> tsc.clock_select == CLK_OFF && !tick;
  endproperty
  a_reset_stop: assert property (p_reset_stop) else $error("clock not off after reset");

  property p_stop_hold;
    @(posedge core_clk) disable iff (rst)
      tsc.clock_select == CLK_OFF && !cnt_wr |=> cnt == $past(cnt);
  endproperty
  a_stop_hold: assert property (p_stop_hold) else $error("stopped counter moved");

  property p_tick_only;
    @(posedge core_clk) disable iff (rst) !tick && !cnt_wr |=> $stable(cnt);
  endproperty
  a_tick_only: assert property (p_tick_only) else $error("counter moved without tick");

  property p_up_wrap;
    @(posedge core_clk) disable iff (rst)
      tick && !cnt_wr && !tsc.center_align_select && cnt == term
      |=> cnt == CNT_ZERO && tsc.overflow_flag;
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up wrap wrong");

  property p_turn_down;
    @(posedge core_clk) disable iff (rst)
      tick && !cnt_wr && tsc.center_align_select && !count_down && cnt == term
      |=> cnt == $past(cnt) - 16'h0001 && tsc.overflow_flag && count_down;
  endproperty
  a_turn_down: assert property (p_turn_down) else $error("up/down turn wrong");

  property p_cnt_clear;
    @(posedge core_clk) disable iff (rst) cnt_wr |=> cnt == CNT_ZERO && !cnt_lat;
  endproperty
  a_cnt_clear: assert property (p_cnt_clear) else $error("counter write did not clear");

  property p_capture;
    @(posedge core_clk) disable iff (rst)
      cap_ev[0] |=> ch_val[0] == $past(cnt) && ch_sc[0].channel_event_flag;
  endproperty
  a_capture: assert property (p_capture) else $error("capture value or flag wrong");

  property p_cap_ro;
    @(posedge core_clk) disable iff (rst)
      (ch_vh_wr[0] || ch_vl_wr[0]) && !cap_ev[0] && !tsc.center_align_select &&
      ch_sc[0].channel_mode == MODE_CAPTURE |=> $stable(ch_val[0]);
  endproperty
  a_cap_ro: assert property (p_cap_ro) else $error("capture value was written");

  property p_sc_unlatch;
    @(posedge core_clk) disable iff (rst) ch_sc_wr[0] |=> !ch_lat[0];
  endproperty
  a_sc_unlatch: assert property (p_sc_unlatch) else $error("latch survived control write");

  property p_irq;
    @(posedge core_clk) disable iff (rst)
      tsc.overflow_flag && tsc.overflow_irq_enable |=> overflow_irq;
  endproperty
  a_irq: assert property (p_irq) else $error("overflow interrupt missing");

  property p_sticky;
    @(posedge core_clk) disable iff (rst)
      tsc.overflow_flag && !tsc_wr |=> tsc.overflow_flag;
  endproperty
  a_sticky: assert property (p_sticky) else $error("overflow flag dropped");

  c_wrap:    cover property (@(posedge core_clk) disable iff (rst) ovf_event);
  c_capture: cover property (@(posedge core_clk) disable iff (rst) cap_ev[0] ##1 ch_vh_rd[0]);
  c_turn:    cover property (@(posedge core_clk) disable iff (rst) count_down && tick);
endmodule : tcap_top

// File: tcap_pins_model.sv
`timescale 1ns/1ps
// Pin side of the timer: capture levels, fixed-rate clock, external clock
module tcap_pins_model #(
  parameter int NCH = 2
) (
  input  wire logic           core_clk,
  input  wire logic [NCH-1:0] pin_req,
  output logic                fixed_clk,
  output logic                ext_clk_pin,
  output logic [NCH-1:0]      ch_pin
);
  logic [1:0]     div  = 2'h0;
  logic [NCH-1:0] pins = '0;
  logic           ext  = 1'b0;
  // Fixed clock is a quarter of the bus rate, never faster than it
  always_ff @(posedge core_clk) begin
    div  <= div + 2'h1;
    pins <= pin_req;
  end
  // External source, 50 ns period: below a quarter of the bus rate
  initial begin
    forever #25 ext = ~ext;
  end
  assign fixed_clk   = div[1];
  assign ext_clk_pin = ext;
  assign ch_pin      = pins;
endmodule : tcap_pins_model

// File: timer_counter_and_input_capture_tb_top.sv
`timescale 1ns/1ps
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
  $display("unexpected %s expected %h seen %h", n, e, s); end end
module timer_counter_and_input_capture_tb_top;
  import tcap_pkg::*;
  logic core_clk, rst, awvalid, wvalid, bready, arvalid, rready, debug_halt;
  logic awready, wready, bvalid, arready, rvalid, fixed_clk, ext_clk_pin, overflow_irq;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, last_resp, pin_req, ch_pin, channel_irq, ch_pin_oe;
  logic [7:0]  v, h, l;
  int          bad_count, checks_done;

  tcap_top #(.NCH(2)) i_tcap_top (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .fixed_clk(fixed_clk), .ext_clk_pin(ext_clk_pin), .ch_pin(ch_pin), .debug_halt(debug_halt),
    .overflow_irq(overflow_irq), .channel_irq(channel_irq), .ch_pin_oe(ch_pin_oe));
  tcap_pins_model #(.NCH(2)) i_tcap_pins_model (.core_clk(core_clk), .pin_req(pin_req),
    .fixed_clk(fixed_clk), .ext_clk_pin(ext_clk_pin), .ch_pin(ch_pin));

  // Bus clock, 125 MHz
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask : cyc

  // Write: both channels offered together, each dropped once taken;
  // response ready stays high so back-to-back calls never toggle it
  task automatic axw(input logic [11:0] a, input logic [7:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a; wdata <= {24'h000000, d}; wstrb <= 4'hf;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (awvalid && awready === 1'b1) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wvalid && wready === 1'b1) begin wd = 1'b1; wvalid <= 1'b0; end
    end
    do @(posedge core_clk); while (bvalid !== 1'b1);
    last_resp = bresp;
  endtask : axw

  // Read: address held until taken, data taken at the rvalid edge
  task automatic axr(input logic [11:0] a, output logic [7:0] d);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge core_clk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge core_clk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    last_resp = rresp;
  endtask : axr

  // Read a live byte with the counter frozen; latches stay untouched
  task automatic hread(input logic [11:0] a, output logic [7:0] d);
    debug_halt <= 1'b1;
    cyc(2);
    axr(a, d);
    debug_halt <= 1'b0;
  endtask : hread

  task automatic t_reset;
    axr(OFF_TSC, v); `CHK("tsc", 8'h00, v)
    axr(CH_BASE, v); `CHK("chsc", 8'h00, v)
    cyc(50); hread(OFF_CNT_LO, v); `CHK("cnt stopped", 8'h00, v)
    `CHK("pin oe", 2'b00, ch_pin_oe)
    axr(12'h100, v); `CHK("rd resp", RESP_SLVERR, last_resp)
    axw(12'h100, 8'h11); `CHK("wr resp", RESP_SLVERR, last_resp)
    $display("test reset done");
  endtask : t_reset

  // Limited up count with interrupt, then read-then-write clear
  task automatic t_overflow;
    axw(OFF_MOD_LO, 8'h05); axw(OFF_CNT_LO, 8'h00); axw(OFF_TSC, 8'h48);
    cyc(20);
    axr(OFF_TSC, v); `CHK("ovf set", 8'hc8, v)
    `CHK("ovf irq", 1'b1, overflow_irq)
    // Stop the clock first so no wrap can land on the clearing write
    axw(OFF_TSC, 8'hc0); axr(OFF_TSC, v); axw(OFF_TSC, 8'h40); cyc(3);
    axr(OFF_TSC, v); `CHK("ovf clr", 8'h40, v)
    `CHK("ovf irq off", 1'b0, overflow_irq)
    $display("test overflow done");
  endtask : t_overflow

  // Free run: no flag early, flag after a full 16-bit lap
  task automatic t_free;
    axw(OFF_MOD_LO, 8'h00); axw(OFF_CNT_LO, 8'h00); axw(OFF_TSC, 8'h08);
    cyc(1000); axr(OFF_TSC, v); `CHK("no early ovf", 8'h08, v)
    cyc(65000); axr(OFF_TSC, v); `CHK("wrap ovf", 8'h88, v)
    $display("test free done");
  endtask : t_free

  // Up/down count never passes the modulus and flags at the turn
  task automatic t_updown;
    axw(OFF_TSC, 8'h00); axw(OFF_MOD_LO, 8'h03); axw(OFF_CNT_LO, 8'h00); axw(OFF_TSC, 8'h28);
    for (int i = 0; i < 8; i++) begin
      hread(OFF_CNT_LO, v); `CHK("updown range", 1'b1, v <= 8'h03)
      cyc(i + 1);
    end
    axr(OFF_TSC, v); `CHK("updown ovf", 8'ha8, v)
    axw(OFF_TSC, 8'h00); axw(OFF_MOD_LO, 8'h00);
    $display("test updown done");
  endtask : t_updown

  // Each source moves the counter; off keeps it; counter write zeroes it
  task automatic t_sources;
    for (int s = 1; s < 4; s++) begin
      axw(OFF_TSC, {3'b000, s[1:0], 3'b000}); axw(OFF_CNT_HI, 8'h77);
      cyc(200); hread(OFF_CNT_LO, v); `CHK("src runs", 1'b1, v != 8'h00)
    end
    axw(OFF_TSC, 8'h00); hread(OFF_CNT_LO, h); cyc(100);
    hread(OFF_CNT_LO, v); `CHK("off keeps", h, v)
    axw(OFF_CNT_LO, 8'h12); hread(OFF_CNT_LO, v); `CHK("cnt zero", 8'h00, v)
    $display("test sources done");
  endtask : t_sources

  // Capture in debug halt, read-only value, then edge codes 01, 10 and 11
  task automatic t_capture;
    axw(OFF_TSC, 8'h08); axw(CH_BASE, 8'h44); cyc(30);
    debug_halt <= 1'b1; cyc(2);
    axr(OFF_CNT_HI, h); axr(OFF_CNT_LO, l);
    pin_req <= 2'b01; cyc(5);
    axr(CH_BASE + CH_VH_OFF, v); `CHK("cap hi", h, v)
    axr(CH_BASE + CH_VL_OFF, v); `CHK("cap lo", l, v)
    `CHK("ch irq", 1'b1, channel_irq[0])
    axr(CH_BASE, v); `CHK("ch flag", 8'hc4, v)
    axw(CH_BASE + CH_VL_OFF, 8'h5a);
    axr(CH_BASE + CH_VL_OFF, v); `CHK("val ro", l, v)
    debug_halt <= 1'b0;
    for (int e = 1; e < 4; e++) begin
      for (int r = 0; r < 2; r++) begin
        axr(CH_BASE, v); axw(CH_BASE, {4'h0, e[1:0], 2'b00});
        pin_req <= {1'b0, r[0]}; cyc(5); axr(CH_BASE, v);
        `CHK("edge flag", (e == 3) || (e == 1 && r == 1) || (e == 2 && r == 0), v[7])
      end
    end
    $display("test capture done");
  endtask : t_capture

  // Software compare on channel 1 with edge bits 00: flag only, pin idle
  task automatic t_compare;
    axw(OFF_TSC, 8'h00); axw(CH_BASE + CH_STRIDE, 8'h10);
    axw(CH_BASE + CH_STRIDE + CH_VH_OFF, 8'h00); axw(CH_BASE + CH_STRIDE + CH_VL_OFF, 8'h40);
    axw(OFF_CNT_LO, 8'h00); axw(OFF_TSC, 8'h08); cyc(100);
    axr(CH_BASE + CH_STRIDE, v); `CHK("cmp flag", 8'h90, v)
    `CHK("cmp pin oe", 2'b00, ch_pin_oe)
    `CHK("cmp irq", 1'b0, channel_irq[1])
    $display("test compare done");
  endtask : t_compare

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : complete_run

  // Watchdog sized well past the free-running lap
  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    complete_run();
  end

  initial begin
    rst = 1'b1; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0; rready = 1'b0;
    awaddr = 12'h000; araddr = 12'h000; wdata = 32'h00000000; wstrb = 4'h0;
    debug_halt = 1'b0; pin_req = 2'b00; bad_count = 0; checks_done = 0;
    cyc(20);
    rst <= 1'b0;
    cyc(1);
    t_reset(); t_overflow(); t_free(); t_updown(); t_sources(); t_capture(); t_compare();
    complete_run();
  end
endmodule : timer_counter_and_input_capture_tb_top
